//--- hw/wrtp_pkg.sv
// package: constants, register map and types of the wordlength reduce / track pack block
package wrtp_pkg;
  // ********************************************************
  // bank geometry
  // ********************************************************
  localparam int BANK_CH    = 8;
  localparam int SAMPLE_W   = 24;
  localparam int SLOT_W     = 20;
  localparam int BANK_IN_W  = BANK_CH * SAMPLE_W;
  localparam int BANK_MED_W = BANK_CH * SLOT_W;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam int          CTRL_RED_LSB    = 0;
  localparam int          CTRL_WL20_BIT   = 3;
  localparam int          CTRL_RATE_LSB   = 4;
  localparam int          CTRL_PACK_BIT   = 8;
  localparam int          CTRL_MED20_BIT  = 9;
  localparam int          CTRL_TRACK_LSB  = 10;
  localparam logic [31:0] CTRL_MASK       = 32'h0000_0F3F;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam int          STAT_DTRACK_LSB = 0;
  localparam int          STAT_DMED20_BIT = 2;
  localparam int          STAT_LOCK_BIT   = 3;
  localparam int          STAT_ETRACK_LSB = 4;
  localparam int          STAT_EMED20_BIT = 6;
  localparam int          STAT_BAD_BIT    = 7;

  // ********************************************************
  // track-mode tag and dither
  // ********************************************************
  localparam logic [3:0]  TAG_SIX16       = 4'hA;
  localparam logic [3:0]  TAG_FOUR16      = 4'h5;
  localparam logic [3:0]  TAG_SIX20       = 4'hC;
  localparam logic [4:0]  TAG_LOCK_FRAMES = 5'h10;
  localparam logic [4:0]  TAG_LOCK_LAST   = TAG_LOCK_FRAMES - 5'h01;
  localparam logic [31:0] LFSR_SEED       = 32'hACE1_2B47;
  localparam logic [31:0] LFSR_TAPS       = 32'h8020_0003;
  localparam logic [9:0]  DITHER_BIAS     = 10'h0FF;

  typedef enum logic [2:0] {
    RED_FLAT           = 3'h0,
    RED_SHAPER_LEVEL_1 = 3'h1,
    RED_SHAPER_LEVEL_2 = 3'h2,
    RED_SHAPER_LEVEL_3 = 3'h3,
    RED_SHAPER_LEVEL_4 = 3'h4
  } wrtp_red_t;
  typedef enum logic [1:0] {TRK_NATIVE = 2'h0, TRK_SIX = 2'h1, TRK_FOUR = 2'h2} wrtp_track_t;
  typedef enum logic [1:0] {WL_16 = 2'h0, WL_20 = 2'h1, WL_24 = 2'h2} wrtp_wl_t;
  typedef enum logic [1:0] {RATE_44K1 = 2'h0, RATE_48K = 2'h1, RATE_96K = 2'h2} wrtp_rate_t;
endpackage

//--- hw/wrtp_ch_if.sv
// interface between the top and one reducer channel
`timescale 1ns/1ps
`default_nettype none
interface wrtp_ch_if;
  import wrtp_pkg::*;
  logic                       valid;
  logic signed [SAMPLE_W-1:0] sample;
  wrtp_red_t                  mode;
  wrtp_wl_t                   wl;
  wrtp_rate_t                 rate;
  logic signed [SAMPLE_W-1:0] q;
  logic                       q_valid;
  modport ctl (output valid, sample, mode, wl, rate, input q, q_valid);
  modport ch  (input valid, sample, mode, wl, rate, output q, q_valid);
endinterface
`default_nettype wire

//--- hw/wrtp_reduce_ch.sv
// one channel of the wordlength reducer: tpdf dither with error-feedback shaping
`timescale 1ns/1ps
`default_nettype none
module wrtp_reduce_ch #(
  parameter logic [31:0] SEED = 32'h0000_0001
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // sample channel
  wrtp_ch_if.ch    chn
);
  import wrtp_pkg::*;
  localparam int EW = 28;
  localparam logic signed [EW-1:0] QMAX = 28'sh07FFFFF;
  localparam logic signed [EW-1:0] QMIN = -28'sh0800000;

  // ********************************************************
  // error filter coefficients, in sixteenths
  // ********************************************************
  function automatic logic signed [5:0] coef(input wrtp_red_t m, input wrtp_rate_t r,
                                             input wrtp_wl_t w, input int k);
    logic signed [5:0] c;
    c = 6'sh00;
    case (m) // R2 R3
      RED_SHAPER_LEVEL_1: c = (k == 0) ? 6'sh04 : 6'sh00;
      RED_SHAPER_LEVEL_2: c = (k == 0) ? 6'sh0C : (k == 1) ? -6'sh04 : 6'sh00;
      RED_SHAPER_LEVEL_3: c = (k == 0) ? 6'sh14 : (k == 1) ? -6'sh0C : 6'sh04;
      RED_SHAPER_LEVEL_4: c = (k == 0) ? 6'sh1A : (k == 1) ? -6'sh14 : 6'sh08;
      default:            c = 6'sh00;
    endcase
    // audio band is a smaller share of nyquist at 96 kHz, so less lift is needed
    if (r == RATE_96K) begin // R4
      c = c >>> 1;
    end else if (r == RATE_48K && c > 6'sh04) begin // R4
      c = c - 6'sh01;
    end
    if (w == WL_20 && c > 6'sh04) begin // R4
      c = c - 6'sh01;
    end
    return c;
  endfunction

  // ********************************************************
  // datapath
  // ********************************************************
  logic [31:0]          lfsr_r;
  logic signed [EW-1:0] err_r [3];
  logic signed [EW+6:0] acc;
  logic signed [EW-1:0] fb;
  logic signed [EW-1:0] v;
  logic signed [EW-1:0] w;
  logic signed [EW-1:0] keep;
  logic signed [EW-1:0] qv;
  logic signed [EW-1:0] e;
  logic signed [9:0]    dith;

  always_comb begin
    acc = '0;
    for (int k = 0; k < 3; k++) begin
      acc = acc + (EW+7)'(coef(chn.mode, chn.rate, chn.wl, k) * err_r[k]);
    end
    fb   = EW'(acc >>> 4);
    v    = EW'(chn.sample) - fb; // R1
    // two uniform sources one output lsb wide: flat noise near -93.4 dBFS at 16 bits
    dith = $signed(10'({2'h0, lfsr_r[7:0]} + {2'h0, lfsr_r[15:8]} - DITHER_BIAS)); // R5 R16
    keep = (chn.wl == WL_20) ? ~EW'(28'h000000F) : ~EW'(28'h00000FF);
    if (chn.wl == WL_20) begin
      dith = dith >>> 4;
    end
    w  = v + EW'(dith);
    qv = w & keep;
    if (qv > QMAX) begin
      qv = QMAX & keep;
    end else if (qv < QMIN) begin
      qv = QMIN;
    end
    // a clipped sample feeds a large error back; shapers assume headroom
    e = qv - v; // R1
    if (chn.wl == WL_24) begin
      qv = EW'(chn.sample);
      e  = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfsr_r <= SEED;
    end else if (chn.valid) begin
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1); // R16
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_r[0] <= '0;
      err_r[1] <= '0;
      err_r[2] <= '0;
    end else if (chn.valid) begin
      err_r[0] <= e; // R1
      err_r[1] <= err_r[0];
      err_r[2] <= err_r[1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chn.q       <= '0;
      chn.q_valid <= 1'b0;
    end else begin
      chn.q_valid <= chn.valid;
      if (chn.valid) begin
        chn.q <= qv[SAMPLE_W-1:0];
      end
    end
  end

  property p_lfsr_steps;
    @(posedge clk) disable iff (!nrst) chn.valid |=> lfsr_r != $past(lfsr_r);
  endproperty
  a_lfsr_steps: assert property (p_lfsr_steps) else $error("dither source did not advance"); // R16

  property p_dither_bound;
    @(posedge clk) disable iff (!nrst)
      chn.valid && chn.wl == WL_16 |-> dith <= 10'sh0FF && dith >= -10'sh0FF;
  endproperty
  a_dither_bound: assert property (p_dither_bound) else $error("dither out of range"); // R5

  property p_lsbs_cleared;
    @(posedge clk) disable iff (!nrst)
      chn.q_valid && $past(chn.wl) == WL_16 |-> chn.q[7:0] == 8'h00;
  endproperty
  a_lsbs_cleared: assert property (p_lsbs_cleared) else $error("low bits kept in 16-bit output"); // R1
endmodule
`default_nettype wire

//--- hw/wrtp_top.sv
// top of the wordlength reduce and track pack block with its apb registers
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: shaping filters the truncation error and subtracts it from following samples.
// R2: reducer offers flat dither plus four selectable shaping levels.
// R3: each higher shaping level shapes the noise more strongly.
// R4: shaper coefficients follow the sample rate and output wordlength automatically.
// R5: flat 16-bit dither noise sits near -93.4 dBFS rms.
// R6: 16-bit medium carries eight 16-bit, six 20-bit or four 24-bit channels.
// R7: 20-bit medium carries eight 20-bit or six 24-bit channels.
// R8: encoder embeds a track-mode tag; decoder locks onto it automatically.
// R9: packing and unpacking always treat the whole eight-track bank together.
// R10: packed data is rebuilt by the matching decoder, both schemes included.
// R11: packing works with split-rate links, e.g. stereo 96 kHz 24-bit on 16-bit.
// R12: primary track holds the top 16 or 20 bits, secondary the rest.
// R13: six-channel secondaries: channels 1,3,5 in track 7; 2,4,6 in track 8.
// R14: four-channel secondary of channel n goes to track n plus four.
// R15: the track-mode tag always travels in track eight.
// R16: fresh triangular dither per sample, one sample per channel per period.
module wrtp_top (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              nrst,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [7:0]                        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // converter samples in, 24-bit, channel 1 in the low bits
  input  wire logic                              in_valid,
  input  wire logic [wrtp_pkg::BANK_IN_W-1:0]    in_samples,
  // medium out, 20-bit slots, 16-bit words top-aligned
  output logic                                   med_valid,
  output logic      [wrtp_pkg::BANK_MED_W-1:0]   med_slots,
  // medium in
  input  wire logic                              rx_valid,
  input  wire logic [wrtp_pkg::BANK_MED_W-1:0]   rx_slots,
  // decoded samples out
  output logic                                   dec_valid,
  output logic      [wrtp_pkg::BANK_IN_W-1:0]    dec_samples
);
  import wrtp_pkg::*;

  // ********************************************************
  // apb registers
  // ********************************************************
  function automatic logic addr_known(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STATUS);
  endfunction

  logic [31:0] ctrl_r;
  logic [31:0] rd_mux;
  logic [31:0] status;
  wrtp_track_t f_trk_r;
  logic        f_med20_r;
  logic        f_bad_r;
  wrtp_track_t dec_trk_r;
  logic        dec_med20_r;
  wrtp_track_t pend_trk_r;
  logic        pend_med20_r;
  logic [4:0]  lock_cnt_r;
  logic        locked;

  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable & pready;

  always_comb begin
    locked = (lock_cnt_r == TAG_LOCK_LAST) && (dec_trk_r == pend_trk_r)
             && (dec_med20_r == pend_med20_r);
    status = '0;
    status[STAT_DTRACK_LSB +: 2] = dec_trk_r;
    status[STAT_DMED20_BIT]      = dec_med20_r;
    status[STAT_LOCK_BIT]        = locked;
    status[STAT_ETRACK_LSB +: 2] = f_trk_r;
    status[STAT_EMED20_BIT]      = f_med20_r;
    status[STAT_BAD_BIT]         = f_bad_r;
    case (paddr)
      ADDR_CTRL:   rd_mux = ctrl_r;
      ADDR_STATUS: rd_mux = status;
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      // zero wait: the access phase always completes in its first cycle
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_known(paddr);
      prdata  <= (apb_setup & ~pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
    end else if (apb_acc && pwrite && paddr == ADDR_CTRL) begin
      ctrl_r <= pwdata & CTRL_MASK;
    end
  end

  // ********************************************************
  // configuration decode
  // ********************************************************
  wrtp_red_t   red_mode;
  wrtp_wl_t    red_wl;
  wrtp_rate_t  red_rate;
  wrtp_track_t trk;
  logic        med_eff;
  logic        cfg_bad;

  always_comb begin
    red_mode = (ctrl_r[CTRL_RED_LSB +: 3] > 3'h4) ? RED_FLAT
             : wrtp_red_t'(ctrl_r[CTRL_RED_LSB +: 3]); // R2
    red_rate = (ctrl_r[CTRL_RATE_LSB +: 2] == 2'h3) ? RATE_48K
             : wrtp_rate_t'(ctrl_r[CTRL_RATE_LSB +: 2]);
    med_eff  = ctrl_r[CTRL_PACK_BIT] ? ctrl_r[CTRL_MED20_BIT] : ctrl_r[CTRL_WL20_BIT];
    trk      = wrtp_track_t'(ctrl_r[CTRL_TRACK_LSB +: 2]);
    cfg_bad  = 1'b0;
    if (!ctrl_r[CTRL_PACK_BIT]) begin
      trk = TRK_NATIVE;
    end else if (ctrl_r[CTRL_TRACK_LSB +: 2] == 2'h3 || (med_eff && trk == TRK_FOUR)) begin
      // only the listed track modes exist per medium; others fall back to native
      trk     = TRK_NATIVE; // R6 R7
      cfg_bad = 1'b1;
    end
    case (trk)
      TRK_SIX:  red_wl = med_eff ? WL_24 : WL_20; // R6 R7
      TRK_FOUR: red_wl = WL_24; // R6
      default:  red_wl = med_eff ? WL_20 : WL_16;
    endcase
  end

  // configuration is caught with the frame so one bank is never split over two modes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      f_trk_r   <= TRK_NATIVE;
      f_med20_r <= 1'b0;
      f_bad_r   <= 1'b0;
    end else if (in_valid) begin
      f_trk_r   <= trk; // R9
      f_med20_r <= med_eff;
      f_bad_r   <= cfg_bad;
    end
  end

  // ********************************************************
  // wordlength reducers, one per channel
  // ********************************************************
  logic signed [SAMPLE_W-1:0] red_q [BANK_CH];
  logic [BANK_CH-1:0]         red_v;

  generate
    for (genvar i = 0; i < BANK_CH; i++) begin : g_ch
      wrtp_ch_if chif ();
      assign chif.valid  = in_valid; // R16
      assign chif.sample = in_samples[i*SAMPLE_W +: SAMPLE_W];
      assign chif.mode   = red_mode;
      assign chif.wl     = red_wl; // R4
      assign chif.rate   = red_rate; // R4
      assign red_q[i]    = chif.q;
      assign red_v[i]    = chif.q_valid;
      wrtp_reduce_ch #(
        .SEED (LFSR_SEED ^ {8{4'(i)}})
      ) u_red (
        .clk  (clk),
        .nrst (nrst),
        .chn  (chif.ch)
      );
    end
  endgenerate

  // ********************************************************
  // track packer
  // ********************************************************
  // words are built in 20-bit slots; a 16-bit word occupies the low 16 of wd
  logic [SLOT_W-1:0]     wd [BANK_CH];
  logic [BANK_MED_W-1:0] med_nxt;

  always_comb begin
    for (int i = 0; i < BANK_CH; i++) begin
      wd[i] = f_med20_r ? red_q[i][23:4] : {4'h0, red_q[i][23:8]}; // R12
    end
    case (f_trk_r)
      TRK_SIX: begin
        wd[6] = '0;
        wd[7] = '0;
        for (int k = 0; k < 3; k++) begin
          if (f_med20_r) begin
            wd[6][19-4*k -: 4] = red_q[2*k][3:0]; // R13
            wd[7][19-4*k -: 4] = red_q[2*k+1][3:0]; // R13
          end else begin
            wd[6][15-4*k -: 4] = red_q[2*k][7:4]; // R13
            wd[7][15-4*k -: 4] = red_q[2*k+1][7:4]; // R13
          end
        end
        wd[7][3:0] = f_med20_r ? TAG_SIX20 : TAG_SIX16; // R8 R15
      end
      TRK_FOUR: begin
        // a split-rate stereo pair lands in channels 1-4 like any other frame
        for (int k = 0; k < 4; k++) begin
          wd[k+4] = {4'h0, red_q[k][7:0], 8'h00}; // R14 R11
        end
        wd[7][3:0] = TAG_FOUR16; // R8 R15
      end
      default: begin
      end
    endcase
    for (int i = 0; i < BANK_CH; i++) begin
      med_nxt[i*SLOT_W +: SLOT_W] = f_med20_r ? wd[i] : {wd[i][15:0], 4'h0};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      med_valid <= 1'b0;
      med_slots <= '0;
    end else begin
      med_valid <= red_v[0];
      if (red_v[0]) begin
        med_slots <= med_nxt; // R9
      end
    end
  end

  // ********************************************************
  // tag detection and decoder
  // ********************************************************
  logic [SLOT_W-1:0]   rs [BANK_CH];
  logic [SAMPLE_W-1:0] ds [BANK_CH];
  logic [BANK_IN_W-1:0] dec_nxt;
  wrtp_track_t         cand_trk;
  logic                cand_med20;

  always_comb begin
    for (int i = 0; i < BANK_CH; i++) begin
      rs[i] = rx_slots[i*SLOT_W +: SLOT_W];
    end
    // untagged data is native; random audio matching a tag for a whole lock run is unlikely
    cand_trk   = TRK_NATIVE;
    cand_med20 = 1'b0;
    if (rs[7][7:4] == TAG_SIX16) begin // R8 R15
      cand_trk = TRK_SIX;
    end else if (rs[7][7:4] == TAG_FOUR16) begin
      cand_trk = TRK_FOUR;
    end else if (rs[7][3:0] == TAG_SIX20) begin
      cand_trk   = TRK_SIX;
      cand_med20 = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_trk_r   <= TRK_NATIVE;
      pend_med20_r <= 1'b0;
      lock_cnt_r   <= '0;
      dec_trk_r    <= TRK_NATIVE;
      dec_med20_r  <= 1'b0;
    end else if (rx_valid) begin
      if (cand_trk == pend_trk_r && cand_med20 == pend_med20_r) begin
        if (lock_cnt_r != TAG_LOCK_LAST) begin
          lock_cnt_r <= lock_cnt_r + 5'h01;
        end
        if (lock_cnt_r >= TAG_LOCK_LAST - 5'h01) begin
          dec_trk_r   <= pend_trk_r; // R8
          dec_med20_r <= pend_med20_r;
        end
      end else begin
        pend_trk_r   <= cand_trk;
        pend_med20_r <= cand_med20;
        lock_cnt_r   <= '0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < BANK_CH; i++) begin
      ds[i] = {rs[i], 4'h0};
    end
    case (dec_trk_r)
      TRK_SIX: begin
        for (int i = 0; i < BANK_CH; i++) begin
          if (i >= 6) begin
            ds[i] = '0;
          end else if (dec_med20_r) begin
            ds[i] = {rs[i], rs[6+i%2][19-4*(i/2) -: 4]}; // R10 R13
          end else begin
            ds[i] = {rs[i][19:4], rs[6+i%2][19-4*(i/2) -: 4], 4'h0}; // R10 R13
          end
        end
      end
      TRK_FOUR: begin
        for (int k = 0; k < 4; k++) begin
          ds[k]   = {rs[k][19:4], rs[k+4][19:12]}; // R10 R14
          ds[k+4] = '0;
        end
      end
      default: begin
      end
    endcase
    for (int i = 0; i < BANK_CH; i++) begin
      dec_nxt[i*SAMPLE_W +: SAMPLE_W] = ds[i];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_valid   <= 1'b0;
      dec_samples <= '0;
    end else begin
      dec_valid <= rx_valid;
      if (rx_valid) begin
        dec_samples <= dec_nxt; // R9 R10
      end
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  property p_bank_latency;
    @(posedge clk) disable iff (!nrst) in_valid |-> ##2 med_valid;
  endproperty
  a_bank_latency: assert property (p_bank_latency) else $error("bank not packed in 2 cycles"); // R9

  property p_primary16;
    @(posedge clk) disable iff (!nrst)
      med_valid && !$past(f_med20_r) |-> med_slots[19:4] == $past(red_q[0][23:8]);
  endproperty
  a_primary16: assert property (p_primary16) else $error("primary track wrong"); // R12

  property p_six_sec;
    @(posedge clk) disable iff (!nrst)
      med_valid && $past(f_trk_r) == TRK_SIX && !$past(f_med20_r)
      |-> med_slots[6*SLOT_W+19 -: 4] == $past(red_q[0][7:4])
          && med_slots[7*SLOT_W+15 -: 4] == $past(red_q[3][7:4]);
  endproperty
  a_six_sec: assert property (p_six_sec) else $error("six-channel secondary misplaced"); // R13

  property p_four_sec;
    @(posedge clk) disable iff (!nrst)
      med_valid && $past(f_trk_r) == TRK_FOUR
      |-> med_slots[4*SLOT_W+19 -: 8] == $past(red_q[0][7:0]);
  endproperty
  a_four_sec: assert property (p_four_sec) else $error("four-channel secondary misplaced"); // R14

  property p_tag_track8;
    @(posedge clk) disable iff (!nrst)
      med_valid && $past(f_trk_r) == TRK_FOUR |-> med_slots[7*SLOT_W+7 -: 4] == TAG_FOUR16;
  endproperty
  a_tag_track8: assert property (p_tag_track8) else $error("tag missing in track eight"); // R15

  property p_lock_switch;
    @(posedge clk) disable iff (!nrst)
      $changed(dec_trk_r) |-> $past(rx_valid) && $past(lock_cnt_r) == TAG_LOCK_LAST - 5'h01;
  endproperty
  a_lock_switch: assert property (p_lock_switch) else $error("decode mode changed unlocked"); // R8

  property p_four_decode;
    @(posedge clk) disable iff (!nrst)
      rx_valid && dec_trk_r == TRK_FOUR
      |=> dec_valid && dec_samples[23:8] == $past(rx_slots[19:4])
          && dec_samples[7:0] == $past(rx_slots[4*SLOT_W+19 -: 8]);
  endproperty
  a_four_decode: assert property (p_four_decode) else $error("four-channel decode wrong"); // R10

  property p_refuse_four20;
    @(posedge clk) disable iff (!nrst)
      in_valid && ctrl_r[CTRL_PACK_BIT] && ctrl_r[CTRL_MED20_BIT]
      && ctrl_r[CTRL_TRACK_LSB +: 2] == 2'h2 |=> f_trk_r == TRK_NATIVE && f_bad_r;
  endproperty
  a_refuse_four20: assert property (p_refuse_four20) else $error("four mode on 20-bit medium"); // R7
endmodule
`default_nettype wire

//--- tb/wrtp_recorder.sv
// recorder model: replays each written bank one cycle later
`timescale 1ns/1ps
`default_nettype none
module wrtp_recorder (
  // clock
  input  wire logic                          clk,
  // record side
  input  wire logic                          wr_valid,
  input  wire logic [wrtp_pkg::BANK_MED_W-1:0] wr_slots,
  // replay side
  output logic                               pb_valid,
  output logic      [wrtp_pkg::BANK_MED_W-1:0] pb_slots
);
  import wrtp_pkg::*;
  initial begin
    pb_valid = 1'b0;
    pb_slots = '0;
  end
  // all eight tracks travel together; between frames the lines toggle, never hold stale data
  always @(posedge clk) begin
    pb_valid <= wr_valid;
    pb_slots <= wr_valid ? wr_slots : ~pb_slots;
  end
endmodule
`default_nettype wire

//--- tb/tb_wordlength_reduce_track_pack.sv
// testbench: registers, track packing on both media, tag lock, decode, flat dither
`timescale 1ns/1ps
`default_nettype none
module tb_wordlength_reduce_track_pack;
  import wrtp_pkg::*;
  logic                  clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata, r;
  logic                  pready, pslverr, err, in_valid = 1'b0, med_valid, rx_valid, dec_valid;
  logic [BANK_IN_W-1:0]  in_samples = '0, dec_samples, s;
  logic [BANK_MED_W-1:0] med_slots, rx_slots, e;
  int                    fail_count = 0, n_compared = 0;

  always #2.5 clk = ~clk;

  wrtp_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_samples(in_samples), .med_valid(med_valid),
    .med_slots(med_slots), .rx_valid(rx_valid), .rx_slots(rx_slots),
    .dec_valid(dec_valid), .dec_samples(dec_samples));
  wrtp_recorder rec (.clk(clk), .wr_valid(med_valid), .wr_slots(med_slots),
    .pb_valid(rx_valid), .pb_slots(rx_slots));

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a missing answer ends the run rather than hanging it
  task automatic wait_hi(ref logic sig, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig !== 1'b1 && n < 16);
    if (sig !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: no answer", $time);
      end_of_test();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    wait_hi(pready, n);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic frame(input logic [191:0] x);
    int n;
    in_valid <= 1'b1;
    in_samples <= x;
    @(posedge clk);
    in_valid <= 1'b0;
    wait_hi(med_valid, n);
    chk(192'(n), 192'd2);
  endtask

  function automatic logic [159:0] four16(input logic [191:0] x);
    four16 = '0;
    for (int n = 0; n < 4; n++) begin
      four16[20*n +: 20] = {x[24*n+8 +: 16], 4'h0};
      four16[20*n+80 +: 20] = {x[24*n +: 8], 12'h000};
    end
    four16[147:144] = TAG_FOUR16;
  endfunction

  function automatic logic [159:0] six20(input logic [191:0] x);
    six20 = '0;
    for (int n = 0; n < 6; n++) begin
      six20[20*n +: 20] = x[24*n+4 +: 20];
    end
    six20[139:128] = {x[3:0], x[51:48], x[99:96]};
    six20[159:140] = {x[27:24], x[75:72], x[123:120], 4'h0, TAG_SIX20};
  endfunction

  // ****************
  // scenarios
  // ****************
  task automatic regs_case();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(192'(r), 192'(CTRL_RST));
    apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(192'(r), 192'(CTRL_MASK));
    apb(1'b0, 8'h08, 32'h0);
    chk(192'({err, r}), 192'({1'b1, 32'h0}));
  endtask

  // four tracks on a 20-bit medium does not exist: the frame falls back to native
  task automatic refuse_case();
    apb(1'b1, ADDR_CTRL, 32'h0000_0B00);
    frame(s);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(192'(r & 32'hF0), 192'h0C0);
  endtask

  // seventeen frames: the tag locks at the sixteenth, so the last one decodes in the new mode
  task automatic pack_case(input logic [31:0] ctrl, input logic is20);
    apb(1'b1, ADDR_CTRL, ctrl);
    for (int k = 0; k < 8; k++) s[24*k +: 24] = 24'(24'h13579B + 24'h102030 * k);
    for (int i = 0; i < 17; i++) frame(s);
    repeat (3) @(posedge clk);
    e = is20 ? six20(s) : four16(s);
    chk(192'(med_slots), 192'(e));
    chk(dec_samples, s & ((192'h1 << (is20 ? 144 : 96)) - 192'h1));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(192'(r), is20 ? 192'h5D : 192'h2A);
  endtask

  // flat dither moves the output by one lsb at most; shaping feedback adds a few more
  task automatic dither_case(input logic [31:0] ctrl, input int lim);
    int dlt;
    apb(1'b1, ADDR_CTRL, ctrl);
    repeat (3) frame(s);
    dlt = int'($signed(med_slots[19:4])) - int'($signed(s[23:8]));
    chk(192'(med_slots[3:0]), 192'h0);
    chk(192'(dlt >= -lim && dlt <= lim), 192'h1);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    regs_case();
    pack_case(32'h0000_0900, 1'b0);
    pack_case(32'h0000_0700, 1'b1);
    refuse_case();
    dither_case(32'h0, 1);
    dither_case(32'h0000_0014, 10);
    end_of_test();
  end
endmodule
`default_nettype wire
